// *** design/timer16_wave.sv ***
// Function
// - counting gated by one-cycle timer tick enable
// - frequency-correct modes load compares at BOTTOM
// - channel a mode nonzero takes over pin, except in reserved mode or with toggle outside its allowed modes
// - channel b mode nonzero takes over pin, except in reserved mode or with toggle outside non-PWM
// - pin driver only when direction bit set
// - non-PWM: off, toggle, clear, set on match
// - fast PWM: clear/set on match, opposite at BOTTOM
// - fast PWM toggle only channel a, modes 14/15
// - fast PWM: clear/set ignores match when compare equals TOP
// - dual-slope toggle only channel a, modes 9/11
// - dual-slope: clear up, set down, or inverse
// - mode from low and high control bits
// - normal and CTC: tops, immediate update, MAX flag
// - phase correct tops, update TOP, flag BOTTOM
// - fast PWM tops, update BOTTOM, flag TOP
// - frequency-correct tops, update and flag BOTTOM
// - dual slope up, turn at TOP with no hold, down
`default_nettype none
module timer16_wave (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // avalon-mm slave
  input wire logic [7:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  input wire logic [3:0] byteenable_i,
  output logic [31:0] readdata_o,
  output logic waitrequest_o,
  // prescaled timer tick and normal port data
  input wire logic timer_tick_enable_i,
  input wire logic [1:0] port_data_i,
  // compare output pins
  output logic chan_a_pin_o,
  output logic chan_a_pin_oe_o,
  output logic chan_b_pin_o,
  output logic chan_b_pin_oe_o,
  // interrupt
  output logic irq_o
);

  // ==========================================================
  // helpers
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] be);
    merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction
  // compare output action, returns next level; falling is high on a down slope
  function automatic logic apply_mode(input logic cur, input logic [1:0] om, input logic falling);
    unique case (om)
      timer16_pkg::OM_TOGGLE: apply_mode = ~cur;
      timer16_pkg::OM_CLEAR: apply_mode = falling;
      timer16_pkg::OM_SET: apply_mode = ~falling;
      default: apply_mode = cur;
    endcase
  endfunction

  // ==========================================================
  // state
  timer16_pkg::ctrl_a_t ctrl_a_r;
  logic [1:0] ctrl_b_r;
  logic [15:0] buf_a_r;
  logic [15:0] buf_b_r;
  logic [15:0] cmp_a_r;
  logic [15:0] cmp_b_r;
  logic [15:0] capture_r;
  logic [15:0] cnt_r;
  logic [2:0] status_r;
  logic [2:0] mask_r;
  logic [1:0] pin_dir_r;
  logic wave_a_r;
  logic wave_b_r;
  timer16_pkg::count_dir_t dir_r;
  logic wait_r;
  logic [31:0] rdata_r;

  // ==========================================================
  // mode decode
  logic [3:0] mode;
  logic nonpwm;
  logic fast;
  logic phase_c;
  logic freq_c;
  logic dual;
  logic reserved;
  logic [15:0] top;
  logic at_top;
  logic at_bottom;
  logic going_up;
  logic match_a;
  logic match_b;
  logic ovf_evt;
  logic upd_evt;
  logic override_a;
  logic override_b;
  logic toggle_ok_a;
  logic acc_wr;
  logic cnt_wr;

  assign mode = {ctrl_b_r, ctrl_a_r.waveform_mode_low};
  assign nonpwm = (mode == timer16_pkg::WM_NORMAL) || (mode == timer16_pkg::WM_CTC_CMP)
                  || (mode == timer16_pkg::WM_CTC_CAP);
  assign fast = (mode == timer16_pkg::WM_FAST8) || (mode == timer16_pkg::WM_FAST9)
                || (mode == timer16_pkg::WM_FAST10) || (mode == timer16_pkg::WM_FAST_CAP)
                || (mode == timer16_pkg::WM_FAST_CMP);
  assign phase_c = (mode == timer16_pkg::WM_PC8) || (mode == timer16_pkg::WM_PC9)
                   || (mode == timer16_pkg::WM_PC10) || (mode == timer16_pkg::WM_PC_CAP)
                   || (mode == timer16_pkg::WM_PC_CMP);
  assign freq_c = (mode == timer16_pkg::WM_PFC_CAP) || (mode == timer16_pkg::WM_PFC_CMP);
  assign dual = phase_c || freq_c;
  assign reserved = (mode == timer16_pkg::WM_RESERVED);
  // top source per mode
  always_comb
  begin
    unique case (mode)
      timer16_pkg::WM_PC8, timer16_pkg::WM_FAST8: top = timer16_pkg::TOP_8BIT;
      timer16_pkg::WM_PC9, timer16_pkg::WM_FAST9: top = timer16_pkg::TOP_9BIT;
      timer16_pkg::WM_PC10, timer16_pkg::WM_FAST10: top = timer16_pkg::TOP_10BIT;
      timer16_pkg::WM_CTC_CMP, timer16_pkg::WM_PFC_CMP, timer16_pkg::WM_PC_CMP,
      timer16_pkg::WM_FAST_CMP: top = cmp_a_r;
      timer16_pkg::WM_CTC_CAP, timer16_pkg::WM_PFC_CAP, timer16_pkg::WM_PC_CAP,
      timer16_pkg::WM_FAST_CAP: top = capture_r;
      default: top = timer16_pkg::MAX;
    endcase
  end
  // tick qualified events
  assign at_top = timer_tick_enable_i && (cnt_r == top);
  assign at_bottom = timer_tick_enable_i && (cnt_r == timer16_pkg::BOTTOM);
  assign going_up = (dir_r == timer16_pkg::DIR_UP);
  assign match_a = timer_tick_enable_i && !reserved && (cnt_r == cmp_a_r);
  assign match_b = timer_tick_enable_i && !reserved && (cnt_r == cmp_b_r);
  // overflow point per mode family
  assign ovf_evt = nonpwm ? (timer_tick_enable_i && cnt_r == timer16_pkg::MAX)
                 : fast ? at_top
                 : dual && at_bottom && !going_up;
  // buffered compare load point
  assign upd_evt = fast || freq_c ? at_bottom
                 : phase_c && at_top;
  assign toggle_ok_a = nonpwm || mode == timer16_pkg::WM_FAST_CAP || mode == timer16_pkg::WM_FAST_CMP
                       || mode == timer16_pkg::WM_PFC_CMP || mode == timer16_pkg::WM_PC_CMP;
  assign override_a = (ctrl_a_r.chan_a_output_mode != timer16_pkg::OM_OFF) && !reserved
                      && (ctrl_a_r.chan_a_output_mode != timer16_pkg::OM_TOGGLE || toggle_ok_a);
  assign override_b = (ctrl_a_r.chan_b_output_mode != timer16_pkg::OM_OFF) && !reserved
                      && (ctrl_a_r.chan_b_output_mode != timer16_pkg::OM_TOGGLE || nonpwm);
  assign acc_wr = write_i && !wait_r;
  assign cnt_wr = acc_wr && (address_i == timer16_pkg::ADDR_COUNTER);
  // ==========================================================
  // bus handshake: one wait cycle, then answer
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
      wait_r <= 1'b1;
    else if ((read_i || write_i) && wait_r)
      wait_r <= 1'b0;
    else
      wait_r <= 1'b1;
  end
  // read data captured in the wait cycle; unmapped reads as zero
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
      rdata_r <= 32'h0000_0000;
    else if (read_i && wait_r)
    begin
      unique case (address_i)
        timer16_pkg::ADDR_CTRL_A: rdata_r <= {24'h00_0000, ctrl_a_r.chan_a_output_mode,
                                              ctrl_a_r.chan_b_output_mode, 2'h0,
                                              ctrl_a_r.waveform_mode_low};
        timer16_pkg::ADDR_CTRL_B: rdata_r <= {30'h0000_0000, ctrl_b_r};
        timer16_pkg::ADDR_CMP_A: rdata_r <= {16'h0000, buf_a_r};
        timer16_pkg::ADDR_CMP_B: rdata_r <= {16'h0000, buf_b_r};
        timer16_pkg::ADDR_CAPTURE: rdata_r <= {16'h0000, capture_r};
        timer16_pkg::ADDR_COUNTER: rdata_r <= {16'h0000, cnt_r};
        timer16_pkg::ADDR_IRQ_STATUS: rdata_r <= {29'h0000_0000, status_r};
        timer16_pkg::ADDR_IRQ_MASK: rdata_r <= {29'h0000_0000, mask_r};
        timer16_pkg::ADDR_PIN_DIR: rdata_r <= {30'h0000_0000, pin_dir_r};
        default: rdata_r <= 32'h0000_0000;
      endcase
    end
  end
  // ==========================================================
  // control, direction and mask registers
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      ctrl_a_r <= timer16_pkg::CTRL_A_RESET;
      ctrl_b_r <= timer16_pkg::CTRL_B_RESET;
      mask_r <= timer16_pkg::FLAGS_RESET;
      pin_dir_r <= timer16_pkg::PIN_DIR_RESET;
    end
    else if (acc_wr && byteenable_i[0])
    begin
      if (address_i == timer16_pkg::ADDR_CTRL_A)
        ctrl_a_r <= {writedata_i[7:4], 2'h0, writedata_i[1:0]};
      if (address_i == timer16_pkg::ADDR_CTRL_B)
        ctrl_b_r <= writedata_i[1:0];
      if (address_i == timer16_pkg::ADDR_IRQ_MASK)
        mask_r <= writedata_i[2:0];
      if (address_i == timer16_pkg::ADDR_PIN_DIR)
        pin_dir_r <= writedata_i[1:0];
    end
  end
  // 16-bit compare buffers and capture value
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      buf_a_r <= timer16_pkg::VALUE16_RESET;
      buf_b_r <= timer16_pkg::VALUE16_RESET;
      capture_r <= timer16_pkg::VALUE16_RESET;
    end
    else if (acc_wr)
    begin
      if (address_i == timer16_pkg::ADDR_CMP_A)
        buf_a_r <= merge16(buf_a_r, writedata_i, byteenable_i);
      if (address_i == timer16_pkg::ADDR_CMP_B)
        buf_b_r <= merge16(buf_b_r, writedata_i, byteenable_i);
      if (address_i == timer16_pkg::ADDR_CAPTURE)
        capture_r <= merge16(capture_r, writedata_i, byteenable_i);
    end
  end
  // active compare values: immediate or at the mode's update point
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      cmp_a_r <= timer16_pkg::VALUE16_RESET;
      cmp_b_r <= timer16_pkg::VALUE16_RESET;
    end
    else if (nonpwm || upd_evt)
    begin
      cmp_a_r <= buf_a_r;
      cmp_b_r <= buf_b_r;
    end
  end
  // ==========================================================
  // counter and direction
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      cnt_r <= timer16_pkg::BOTTOM;
      dir_r <= timer16_pkg::DIR_UP;
    end
    else if (cnt_wr)
      cnt_r <= merge16(cnt_r, writedata_i, byteenable_i);
    else if (timer_tick_enable_i && !reserved)
    begin
      if (!dual)
      begin
        dir_r <= timer16_pkg::DIR_UP;
        cnt_r <= (cnt_r == top) ? timer16_pkg::BOTTOM : cnt_r + 16'h0001;
      end
      else if (going_up)
      begin
        if (cnt_r >= top)
        begin
          dir_r <= timer16_pkg::DIR_DOWN;
          cnt_r <= (cnt_r == timer16_pkg::BOTTOM) ? cnt_r : cnt_r - 16'h0001;
        end
        else
          cnt_r <= cnt_r + 16'h0001;
      end
      else if (cnt_r == timer16_pkg::BOTTOM)
      begin
        dir_r <= timer16_pkg::DIR_UP;
        cnt_r <= (top == timer16_pkg::BOTTOM) ? cnt_r : cnt_r + 16'h0001;
      end
      else
        cnt_r <= cnt_r - 16'h0001;
    end
  end
  // ==========================================================
  // sticky status, write one to clear; a new event wins
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
      status_r <= timer16_pkg::FLAGS_RESET;
    else
    begin
      status_r[timer16_pkg::ST_OVERFLOW] <= ovf_evt || (status_r[timer16_pkg::ST_OVERFLOW]
        && !(acc_wr && byteenable_i[0] && address_i == timer16_pkg::ADDR_IRQ_STATUS
        && writedata_i[timer16_pkg::ST_OVERFLOW]));
      status_r[timer16_pkg::ST_MATCH_A] <= match_a || (status_r[timer16_pkg::ST_MATCH_A]
        && !(acc_wr && byteenable_i[0] && address_i == timer16_pkg::ADDR_IRQ_STATUS
        && writedata_i[timer16_pkg::ST_MATCH_A]));
      status_r[timer16_pkg::ST_MATCH_B] <= match_b || (status_r[timer16_pkg::ST_MATCH_B]
        && !(acc_wr && byteenable_i[0] && address_i == timer16_pkg::ADDR_IRQ_STATUS
        && writedata_i[timer16_pkg::ST_MATCH_B]));
    end
  end
  // ==========================================================
  // channel a waveform
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
      wave_a_r <= 1'b0;
    else if (nonpwm && match_a)
      wave_a_r <= apply_mode(wave_a_r, ctrl_a_r.chan_a_output_mode, 1'b0);
    else if (fast)
    begin
      if (ctrl_a_r.chan_a_output_mode[1] && at_top)
        wave_a_r <= ~ctrl_a_r.chan_a_output_mode[0];
      else if (ctrl_a_r.chan_a_output_mode[1] && match_a && cmp_a_r != top)
        wave_a_r <= ctrl_a_r.chan_a_output_mode[0];
      else if (ctrl_a_r.chan_a_output_mode == timer16_pkg::OM_TOGGLE && match_a
               && (mode == timer16_pkg::WM_FAST_CAP || mode == timer16_pkg::WM_FAST_CMP))
        wave_a_r <= ~wave_a_r;
    end
    else if (dual && match_a)
    begin
      if (ctrl_a_r.chan_a_output_mode[1])
        wave_a_r <= apply_mode(wave_a_r, ctrl_a_r.chan_a_output_mode, !going_up);
      else if (ctrl_a_r.chan_a_output_mode == timer16_pkg::OM_TOGGLE
               && (mode == timer16_pkg::WM_PFC_CMP || mode == timer16_pkg::WM_PC_CMP))
        wave_a_r <= ~wave_a_r;
    end
  end
  // channel b waveform, no toggle in the pwm families
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
      wave_b_r <= 1'b0;
    else if (nonpwm && match_b)
      wave_b_r <= apply_mode(wave_b_r, ctrl_a_r.chan_b_output_mode, 1'b0);
    else if (fast && ctrl_a_r.chan_b_output_mode[1])
    begin
      if (at_top)
        wave_b_r <= ~ctrl_a_r.chan_b_output_mode[0];
      else if (match_b && cmp_b_r != top)
        wave_b_r <= ctrl_a_r.chan_b_output_mode[0];
    end
    else if (dual && match_b && ctrl_a_r.chan_b_output_mode[1])
      wave_b_r <= apply_mode(wave_b_r, ctrl_a_r.chan_b_output_mode, !going_up);
  end
  // ==========================================================
  // pins, interrupt and bus outputs, all registered
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      chan_a_pin_o <= 1'b0;
      chan_b_pin_o <= 1'b0;
      chan_a_pin_oe_o <= 1'b0;
      chan_b_pin_oe_o <= 1'b0;
      irq_o <= 1'b0;
    end
    else
    begin
      chan_a_pin_o <= override_a ? wave_a_r : port_data_i[0];
      chan_b_pin_o <= override_b ? wave_b_r : port_data_i[1];
      chan_a_pin_oe_o <= pin_dir_r[timer16_pkg::DIR_BIT_A];
      chan_b_pin_oe_o <= pin_dir_r[timer16_pkg::DIR_BIT_B];
      irq_o <= |(status_r & mask_r);
    end
  end

  assign readdata_o = rdata_r;
  assign waitrequest_o = wait_r;
  // ==========================================================
  // assertions
  a_tick_gates_count: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !timer_tick_enable_i && !cnt_wr |=> $stable(cnt_r)) else $error("counter moved without tick");
  a_pfc_bottom_load: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    freq_c && at_bottom |=> cmp_b_r == $past(buf_b_r)) else $error("compare not loaded at bottom");
  a_pfc_top_hold: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    freq_c && at_top && cnt_r != timer16_pkg::BOTTOM |=> $stable(cmp_b_r)) else $error("compare loaded at top");
  a_pin_a_takeover: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    override_a |=> chan_a_pin_o == $past(wave_a_r)) else $error("channel a pin not overridden");
  a_pin_b_takeover: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    override_b |=> chan_b_pin_o == $past(wave_b_r)) else $error("channel b pin not overridden");
  a_pin_dir_gate: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !pin_dir_r[timer16_pkg::DIR_BIT_A] |=> !chan_a_pin_oe_o) else $error("driver on without direction");
  a_nonpwm_clear: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    nonpwm && match_a && ctrl_a_r.chan_a_output_mode == timer16_pkg::OM_CLEAR |=> !wave_a_r)
    else $error("clear on match failed");
  a_fast_bottom_set: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    fast && at_top && ctrl_a_r.chan_a_output_mode == timer16_pkg::OM_CLEAR |=> wave_a_r)
    else $error("fast pwm not set at bottom");
  a_fast_b_no_toggle: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    fast && ctrl_a_r.chan_b_output_mode == timer16_pkg::OM_TOGGLE |=> $stable(wave_b_r))
    else $error("channel b toggled in fast pwm");
  a_dual_up_clear: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    dual && match_a && going_up && ctrl_a_r.chan_a_output_mode == timer16_pkg::OM_CLEAR |=> !wave_a_r)
    else $error("upcount match did not clear");
  a_normal_wrap: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    mode == timer16_pkg::WM_NORMAL && !cnt_wr && at_top |=> cnt_r == timer16_pkg::BOTTOM
    && status_r[timer16_pkg::ST_OVERFLOW]) else $error("normal mode wrap or flag wrong");
  a_top_reverse: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    dual && !cnt_wr && at_top && going_up && top != timer16_pkg::BOTTOM
    |=> dir_r == timer16_pkg::DIR_DOWN && cnt_r == $past(top) - 16'h0001) else $error("dual slope not reversed");
  a_ctrl_a_unused: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $past(read_i && wait_r && address_i == timer16_pkg::ADDR_CTRL_A) && !wait_r |-> readdata_o[3:2] == 2'h0)
    else $error("unused control bits not zero");
endmodule
`default_nettype wire

// *** design/timer16_pkg.sv ***
`default_nettype none
package timer16_pkg;

  // ==========================================================
  // register byte addresses on the bus
  localparam logic [7:0] ADDR_CTRL_A = 8'h80;
  localparam logic [7:0] ADDR_CTRL_B = 8'h84;
  localparam logic [7:0] ADDR_CMP_A = 8'h88;
  localparam logic [7:0] ADDR_CMP_B = 8'h8c;
  localparam logic [7:0] ADDR_CAPTURE = 8'h90;
  localparam logic [7:0] ADDR_COUNTER = 8'h94;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h98;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h9c;
  localparam logic [7:0] ADDR_PIN_DIR = 8'ha0;

  // ==========================================================
  // reset values
  localparam logic [7:0] CTRL_A_RESET = 8'h00;
  localparam logic [1:0] CTRL_B_RESET = 2'h0;
  localparam logic [15:0] VALUE16_RESET = 16'h0000;
  localparam logic [2:0] FLAGS_RESET = 3'h0;
  localparam logic [1:0] PIN_DIR_RESET = 2'h0;

  // ==========================================================
  // status and mask bit positions, pin direction bit positions
  localparam int unsigned ST_OVERFLOW = 0;
  localparam int unsigned ST_MATCH_A = 1;
  localparam int unsigned ST_MATCH_B = 2;
  localparam int unsigned DIR_BIT_A = 0;
  localparam int unsigned DIR_BIT_B = 1;

  // ==========================================================
  // counter limits
  localparam logic [15:0] BOTTOM = 16'h0000;
  localparam logic [15:0] MAX = 16'hffff;
  localparam logic [15:0] TOP_8BIT = 16'h00ff;
  localparam logic [15:0] TOP_9BIT = 16'h01ff;
  localparam logic [15:0] TOP_10BIT = 16'h03ff;

  // ==========================================================
  // waveform mode codes
  localparam logic [3:0] WM_NORMAL = 4'h0;
  localparam logic [3:0] WM_PC8 = 4'h1;
  localparam logic [3:0] WM_PC9 = 4'h2;
  localparam logic [3:0] WM_PC10 = 4'h3;
  localparam logic [3:0] WM_CTC_CMP = 4'h4;
  localparam logic [3:0] WM_FAST8 = 4'h5;
  localparam logic [3:0] WM_FAST9 = 4'h6;
  localparam logic [3:0] WM_FAST10 = 4'h7;
  localparam logic [3:0] WM_PFC_CAP = 4'h8;
  localparam logic [3:0] WM_PFC_CMP = 4'h9;
  localparam logic [3:0] WM_PC_CAP = 4'ha;
  localparam logic [3:0] WM_PC_CMP = 4'hb;
  localparam logic [3:0] WM_CTC_CAP = 4'hc;
  localparam logic [3:0] WM_RESERVED = 4'hd;
  localparam logic [3:0] WM_FAST_CAP = 4'he;
  localparam logic [3:0] WM_FAST_CMP = 4'hf;

  // ==========================================================
  // output mode codes
  localparam logic [1:0] OM_OFF = 2'h0;
  localparam logic [1:0] OM_TOGGLE = 2'h1;
  localparam logic [1:0] OM_CLEAR = 2'h2;
  localparam logic [1:0] OM_SET = 2'h3;

  // ==========================================================
  // control register a layout
  typedef struct packed {
    logic [1:0] chan_a_output_mode;
    logic [1:0] chan_b_output_mode;
    logic [1:0] unused;
    logic [1:0] waveform_mode_low;
  } ctrl_a_t;

  // count direction of dual-slope modes
  typedef enum logic [1:0] {
    DIR_UP = 2'b01,
    DIR_DOWN = 2'b10
  } count_dir_t;

endpackage
`default_nettype wire

// *** sim/timer16_waveform_mode_decode_test.sv ***
`default_nettype none
module timer16_waveform_mode_decode_test;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // stimulus, observed outputs and bench bookkeeping
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] address_i = 8'h00;
  logic read_i = 1'b0;
  logic write_i = 1'b0;
  logic [31:0] writedata_i = 32'h0;
  logic [3:0] byteenable_i = 4'h0;
  logic timer_tick_enable_i = 1'b0;
  logic [1:0] port_data_i = 2'h0;
  logic [31:0] readdata_o;
  logic waitrequest_o, chan_a_pin_o, chan_a_pin_oe_o, chan_b_pin_o, chan_b_pin_oe_o, irq_o;
  int miscompares = 0;
  int tests_run = 0;
  int seed = 32'hbb75;
  int edges;
  logic last_a;
  logic [15:0] rnd;
  logic [31:0] exp_q[$];
  string name_q[$];

  // 40 mhz clock
  always #12.5 mclk_i = ~mclk_i;

  timer16_wave DUT (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .address_i(address_i), .read_i(read_i), .write_i(write_i),
    .writedata_i(writedata_i), .byteenable_i(byteenable_i), .readdata_o(readdata_o),
    .waitrequest_o(waitrequest_o), .timer_tick_enable_i(timer_tick_enable_i), .port_data_i(port_data_i),
    .chan_a_pin_o(chan_a_pin_o), .chan_a_pin_oe_o(chan_a_pin_oe_o), .chan_b_pin_o(chan_b_pin_o),
    .chan_b_pin_oe_o(chan_b_pin_oe_o), .irq_o(irq_o)
  );

  // ==========================================================
  // compare, verdict and bus cycles
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // one avalon access, held until waitrequest is sampled low
  task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk_i);
    address_i <= a;
    writedata_i <= d;
    byteenable_i <= 4'hf;
    read_i <= rd;
    write_i <= !rd;
    n = 0;
    do
    begin
      @(posedge mclk_i);
      n++;
    end
    while (waitrequest_o !== 1'b0 && n < 20);
    if (waitrequest_o !== 1'b0)
    begin
      miscompares++;
      end_sim();
    end
    else
    begin
      read_i <= 1'b0;
      write_i <= 1'b0;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b0, a, d);
  endtask

  // read notes its expectation for the watcher
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    exp_q.push_back(exp);
    name_q.push_back(what);
    bus(1'b1, a, 32'h0);
  endtask

  // timer ticks on n edges in a row, then two edges for the pins to settle
  task automatic ticks(input int n);
    timer_tick_enable_i <= 1'b1;
    repeat (n) @(posedge mclk_i);
    timer_tick_enable_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
  endtask

  // watcher takes the oldest note whenever read data stands
  always @(posedge mclk_i)
    if (read_i && waitrequest_o === 1'b0)
    begin
      if (exp_q.size() == 0)
        miscompares++;
      else
        check(name_q.pop_front(), readdata_o, exp_q.pop_front());
    end

  // hang guard
  initial
  begin
    repeat (100000) @(posedge mclk_i);
    miscompares++;
    end_sim();
  end

  // ==========================================================
  // main sequence
  initial
  begin
    repeat (4) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    @(posedge mclk_i);
    rd(timer16_pkg::ADDR_CTRL_A, 32'h00, "ctrl_a reset");
    rd(8'hfc, 32'h0, "unmapped read");
    wr(timer16_pkg::ADDR_CTRL_A, 32'hff);
    rd(timer16_pkg::ADDR_CTRL_A, 32'hf3, "ctrl_a unused bits");
    wr(timer16_pkg::ADDR_CTRL_A, 32'h00);
    // random compare buffer values read back
    repeat (3)
    begin
      rnd = 16'($random(seed));
      wr(timer16_pkg::ADDR_CMP_B, {16'h0, rnd});
      rd(timer16_pkg::ADDR_CMP_B, {16'h0, rnd}, "cmp_b buffer");
    end
    // clear on compare a at 2, channel a toggles
    wr(timer16_pkg::ADDR_CMP_B, 32'h0);
    wr(timer16_pkg::ADDR_PIN_DIR, 32'h1);
    wr(timer16_pkg::ADDR_CMP_A, 32'h2);
    wr(timer16_pkg::ADDR_CTRL_B, 32'h1);
    wr(timer16_pkg::ADDR_CTRL_A, 32'h40);
    wr(timer16_pkg::ADDR_COUNTER, 32'h0);
    repeat (2) @(posedge mclk_i);
    check("oe a", chan_a_pin_oe_o, 32'h1);
    check("oe b", chan_b_pin_oe_o, 32'h0);
    last_a = chan_a_pin_o;
    edges = 0;
    timer_tick_enable_i <= 1'b1;
    for (int k = 0; k < 33; k++)
    begin
      @(posedge mclk_i);
      if (k == 29)
        timer_tick_enable_i <= 1'b0;
      if (chan_a_pin_o !== last_a)
        edges++;
      last_a = chan_a_pin_o;
    end
    check("toggles a", edges, 32'd10);
    rd(timer16_pkg::ADDR_IRQ_STATUS, 32'h6, "status");
    check("irq masked", irq_o, 32'h0);
    wr(timer16_pkg::ADDR_IRQ_MASK, 32'h2);
    repeat (2) @(posedge mclk_i);
    check("irq raised", irq_o, 32'h1);
    wr(timer16_pkg::ADDR_IRQ_STATUS, 32'h6);
    repeat (2) @(posedge mclk_i);
    check("irq cleared", irq_o, 32'h0);
    rd(timer16_pkg::ADDR_IRQ_STATUS, 32'h0, "status cleared");
    // set, then clear channel a on the match at 2, counter starts at 0
    wr(timer16_pkg::ADDR_CTRL_A, 32'hc0);
    ticks(3);
    check("pin a set", chan_a_pin_o, 32'h1);
    wr(timer16_pkg::ADDR_CTRL_A, 32'h80);
    ticks(3);
    check("pin a clear", chan_a_pin_o, 32'h0);
    // reserved mode releases channel a to the port; port levels differ from both waves
    port_data_i <= 2'h3;
    wr(timer16_pkg::ADDR_CTRL_B, 32'h3);
    wr(timer16_pkg::ADDR_CTRL_A, 32'h41);
    repeat (2) @(posedge mclk_i);
    check("pin a reserved", chan_a_pin_o, {31'h0, port_data_i[0]});
    // fast 8-bit with channel b toggle stays disconnected
    wr(timer16_pkg::ADDR_CTRL_B, 32'h1);
    wr(timer16_pkg::ADDR_CTRL_A, 32'h11);
    repeat (2) @(posedge mclk_i);
    check("pin b fast toggle", chan_b_pin_o, {31'h0, port_data_i[1]});
    // phase correct, top from capture 4, channel b clears rising and sets falling at 2
    wr(timer16_pkg::ADDR_CTRL_A, 32'h20);
    wr(timer16_pkg::ADDR_CMP_B, 32'h2);
    wr(timer16_pkg::ADDR_CAPTURE, 32'h4);
    wr(timer16_pkg::ADDR_COUNTER, 32'h0);
    wr(timer16_pkg::ADDR_CTRL_B, 32'h2);
    wr(timer16_pkg::ADDR_CTRL_A, 32'h22);
    wr(timer16_pkg::ADDR_IRQ_STATUS, 32'h7);
    ticks(5);
    check("pin b rising clear", chan_b_pin_o, 32'h0);
    rd(timer16_pkg::ADDR_COUNTER, 32'h3, "count after top");
    ticks(4);
    check("pin b falling set", chan_b_pin_o, 32'h1);
    rd(timer16_pkg::ADDR_COUNTER, 32'h1, "count after bottom");
    rd(timer16_pkg::ADDR_IRQ_STATUS, 32'h7, "dual slope status");
    end_sim();
  end
endmodule
`default_nettype wire
